// *** hw/swps_pkg.sv ***
// package: register map, field positions, reset values and timing of the power sequencer
package swps_pkg;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam int              ADDR_W       = 12;
    // word indices; a register's byte address is four times its index
    localparam logic [9:0]      IDX_CTRL     = 10'h000;
    localparam logic [9:0]      IDX_WAKE_LO  = 10'h004;
    localparam logic [9:0]      IDX_WAKE_HI  = 10'h008;
    localparam logic [9:0]      IDX_STATUS   = 10'h024;
    localparam logic [11:0]     OFF_CTRL     = {IDX_CTRL, 2'h0};
    localparam logic [11:0]     OFF_WAKE_LO  = {IDX_WAKE_LO, 2'h0};
    localparam logic [11:0]     OFF_WAKE_HI  = {IDX_WAKE_HI, 2'h0};
    localparam logic [11:0]     OFF_AWAKE    = 12'h00C;
    localparam logic [11:0]     OFF_LEVEL    = 12'h014;
    localparam logic [11:0]     OFF_ASLEEP   = 12'h018;
    localparam logic [11:0]     OFF_STATUS   = {IDX_STATUS, 2'h0};
    localparam logic [1:0]      MEM_REGION   = 2'h1;     // addr[11:10]
    localparam logic [7:0]      MEM_LAST_IDX = 8'h7F;    // retained bytes 0x00..0x7F
    localparam logic [7:0]      VALID_IDX    = 8'hFF;    // retained validity byte
    localparam int              MEM_BYTES    = 128;

    // ****************************************
    // general control fields
    // ****************************************
    localparam int              B_SLEEP_CLK  = 0;
    localparam int              B_SLEEP_GO   = 1;
    localparam int              B_PIN_EN     = 2;
    localparam int              B_PIN_POL    = 3;
    localparam int              B_TIMER_EN   = 4;
    localparam int              B_TIMER_64   = 5;
    localparam int              B_REAPPLY    = 6;
    localparam int              B_POR_LEVEL  = 7;
    localparam logic [7:0]      CTRL_RST     = 8'h08;
    localparam logic [7:0]      CTRL_STORED  = 8'hBD;    // bits 6 and 1 never stored

    // ****************************************
    // power word fields (status layout)
    // ****************************************
    localparam logic [31:0]     PWR_MASK     = 32'h0000_4333;
    localparam logic [31:0]     PWR_CORE_ANA = 32'h0000_0003;
    localparam logic [31:0]     PWR_ALL_ON   = 32'h0000_0033;
    localparam logic [31:0]     PWR_CLK_OFF  = 32'h0000_4000;
    localparam logic [31:0]     AWAKE_RST    = 32'h0000_0033;
    localparam logic [31:0]     ASLEEP_RST   = 32'h0000_4000;
    localparam logic [5:0]      PREV_MASK    = 6'h33;
    localparam logic [5:0]      PREV_RST     = 6'h02;    // analogue converter was on
    localparam int              B_STATE_LO   = 16;
    localparam int              B_PREV_LO    = 24;
    localparam logic [7:0]      POR_LEVEL    = 8'h80;    // arbitrary power-on level code

    // ****************************************
    // timing
    // ****************************************
    localparam int              CLK_PERIOD_PS = 5000;
    localparam int              STEP_TIME_NS  = 100;
    localparam int              STEP_CYCLES   =
        (STEP_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam logic [7:0]      STEP_LAST     = 8'(STEP_CYCLES - 1);

    localparam logic [1:0]      RESP_OKAY    = 2'h0;
    localparam logic [1:0]      RESP_SLVERR  = 2'h2;

    typedef enum logic [2:0] {
        ST_RESET, ST_ASLEEP, ST_WAKING1, ST_WAKING2,
        ST_AWAKE_WAIT, ST_AWAKE, ST_SLEEPING1, ST_SLEEPING2
    } swps_state_t;

endpackage

// *** hw/swps_top.sv ***
// design: sleep and wake power sequencer with an AXI4-Lite register slave
//
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module swps_top (
    input  wire logic                        clk_sys,
    input  wire logic                        arst_n,
    input  wire logic [swps_pkg::ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [swps_pkg::ADDR_W-1:0] s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    input  wire logic                        wake_pin,
    output logic                             io_supply_output_en,
    output logic                             pll_linear_regulator_en,
    output logic                             analogue_converter_en,
    output logic                             core_converter_en,
    output logic                             analogue_converter_pfm,
    output logic                             core_converter_pfm,
    output logic                             tile_clock_off,
    output logic                             sleep_clock_default,
    output logic [7:0]                       supply_level
);
    import swps_pkg::*;

    typedef struct packed {
        logic                    awready;
        logic                    wready;
        logic                    bvalid;
        logic [1:0]              bresp;
        logic                    aw_have;
        logic                    w_have;
        logic [ADDR_W-1:0]       waddr;
        logic [31:0]             wdata;
        logic [3:0]              wstrb;
        logic                    arready;
        logic                    rvalid;
        logic [1:0]              rresp;
        logic [31:0]             rdata;
        logic [7:0]              ctrl;
        logic                    sleep_go;
        logic                    reapply;
        logic [31:0]             wake_lo;
        logic [31:0]             wake_hi;
        logic [31:0]             awake_cfg;
        logic [31:0]             asleep_cfg;
        logic [7:0]              level;
        logic [7:0]              level_out;
        swps_state_t             state;
        logic [7:0]              step;
        logic [31:0]             applied;
        logic [5:0]              prev;
        logic [63:0]             timer;
        logic                    pin_s1;
        logic                    pin_s2;
        logic                    sclk_def;
        logic [MEM_BYTES*8-1:0]  mem;
        logic [7:0]              mem_valid;
    } swps_regs_t;

    // ****************************************
    // reset release
    // ****************************************
    logic [1:0] rst_q;
    logic       rst_n;

    // assert asynchronously, release on the second clock edge
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rst_q <= 2'h0;
        end else begin
            rst_q <= {rst_q[0], 1'b1};
        end
    end
    assign rst_n = rst_q[1];

    // ****************************************
    // helpers
    // ****************************************
    // byte-lane merge of a write into a 32-bit register
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  st);
        logic [31:0] v;
        v = old;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                v[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return v;
    endfunction

    // supply pattern driven while passing through each state except ST_AWAKE, which takes awake_cfg instead
    function automatic logic [31:0] pwr_for(input swps_state_t s,
                                            input logic [31:0] asl);
        logic [31:0] v;
        case (s)
            ST_ASLEEP:     v = asl & PWR_MASK;
            ST_WAKING1:    v = PWR_CORE_ANA;
            ST_WAKING2:    v = PWR_ALL_ON;
            ST_AWAKE_WAIT: v = PWR_ALL_ON;
            ST_SLEEPING1:  v = PWR_ALL_ON | PWR_CLK_OFF;
            ST_SLEEPING2:  v = PWR_CORE_ANA | PWR_CLK_OFF;
            default:       v = 32'h0000_0000;
        endcase
        return v;
    endfunction

    // memory-region decode: index of a retained byte, or the validity byte
    function automatic logic in_mem(input logic [ADDR_W-1:0] a);
        return a[11:10] == MEM_REGION && a[1:0] == 2'h0;
    endfunction

    swps_regs_t r;
    swps_regs_t n;
    logic       pin_hit;
    logic       timer_hit;
    logic       step_done;
    logic [7:0] ridx;
    logic [7:0] widx;

    // ****************************************
    // wake conditions
    // ****************************************
    // only the second synchroniser stage is looked at
    assign pin_hit   = r.ctrl[B_PIN_EN]
                     && (r.pin_s2 == r.ctrl[B_PIN_POL]);
    // high word joins only in 64-bit mode; compared in every state, acted on only while asleep
    assign timer_hit = r.ctrl[B_TIMER_EN] && (r.ctrl[B_TIMER_64]
                     ? r.timer >= {r.wake_hi, r.wake_lo}
                     : r.timer[31:0] >= r.wake_lo);
    assign step_done = r.step == STEP_LAST;
    assign ridx      = s_axi_araddr[9:2];
    assign widx      = r.waddr[9:2];

    // ****************************************
    // next-state logic
    // ****************************************
    always_comb begin
        n = r;
        n.pin_s1   = wake_pin;
        n.pin_s2   = r.pin_s1;
        n.timer    = r.timer + 64'h1;
        n.sleep_go = 1'b0;
        n.reapply  = 1'b0;

        // write address and data are taken independently, in any order
        if (r.awready && s_axi_awvalid) begin
            n.aw_have = 1'b1;
            n.waddr   = s_axi_awaddr;
        end
        if (r.wready && s_axi_wvalid) begin
            n.w_have = 1'b1;
            n.wdata  = s_axi_wdata;
            n.wstrb  = s_axi_wstrb;
        end
        if (r.bvalid && s_axi_bready) begin
            n.bvalid = 1'b0;
        end
        if (r.aw_have && r.w_have && !r.bvalid) begin
            n.aw_have = 1'b0;
            n.w_have  = 1'b0;
            n.bvalid  = 1'b1;
            n.bresp   = RESP_OKAY;
            if (in_mem(r.waddr) && widx <= MEM_LAST_IDX) begin
                if (r.wstrb[0]) begin
                    n.mem[widx[6:0]*8 +: 8] = r.wdata[7:0];
                end
            end else if (in_mem(r.waddr) && widx == VALID_IDX) begin
                if (r.wstrb[0]) begin
                    n.mem_valid = r.wdata[7:0];
                end
            end else begin
                case (r.waddr)
                    OFF_CTRL: begin
                        if (r.wstrb[0]) begin
                            // one-shot bits are pulses, never stored
                            n.ctrl     = r.wdata[7:0] & CTRL_STORED;
                            n.sleep_go = r.wdata[B_SLEEP_GO];
                            n.reapply  = r.wdata[B_REAPPLY];
                        end
                    end
                    OFF_WAKE_LO: n.wake_lo = merge(r.wake_lo, r.wdata, r.wstrb);
                    OFF_WAKE_HI: n.wake_hi = merge(r.wake_hi, r.wdata, r.wstrb);
                    OFF_AWAKE: begin
                        n.awake_cfg = merge(r.awake_cfg, r.wdata, r.wstrb) & PWR_MASK;
                    end
                    OFF_ASLEEP: begin
                        n.asleep_cfg = merge(r.asleep_cfg, r.wdata, r.wstrb) & PWR_MASK;
                    end
                    OFF_LEVEL: begin
                        if (r.wstrb[0]) begin
                            n.level = r.wdata[7:0];
                        end
                    end
                    OFF_STATUS: n.bresp = RESP_OKAY;     // read-only, write ignored
                    default:    n.bresp = RESP_SLVERR;
                endcase
            end
        end
        n.awready = !n.aw_have && !n.bvalid;
        n.wready  = !n.w_have && !n.bvalid;

        // read channel: one read in flight, data held until rready
        if (r.rvalid && s_axi_rready) begin
            n.rvalid = 1'b0;
        end
        if (r.arready && s_axi_arvalid) begin
            n.rvalid = 1'b1;
            n.rresp  = RESP_OKAY;
            n.rdata  = 32'h0000_0000;
            if (in_mem(s_axi_araddr) && ridx <= MEM_LAST_IDX) begin
                n.rdata[7:0] = r.mem[ridx[6:0]*8 +: 8];
            end else if (in_mem(s_axi_araddr) && ridx == VALID_IDX) begin
                n.rdata[7:0] = r.mem_valid;
            end else begin
                case (s_axi_araddr)
                    OFF_CTRL:    n.rdata[7:0] = r.ctrl;
                    OFF_WAKE_LO: n.rdata = r.wake_lo;
                    OFF_WAKE_HI: n.rdata = r.wake_hi;
                    OFF_AWAKE:   n.rdata = r.awake_cfg;
                    OFF_ASLEEP:  n.rdata = r.asleep_cfg;
                    OFF_LEVEL:   n.rdata[7:0] = r.level;
                    OFF_STATUS: begin
                        n.rdata = r.applied;
                        n.rdata[B_STATE_LO +: 3] = r.state;
                        n.rdata[B_PREV_LO +: 6]  = r.prev;
                    end
                    default: n.rresp = RESP_SLVERR;
                endcase
            end
        end
        n.arready = !n.rvalid;

        // sequencer: each intermediate state dwells one step time
        n.step = step_done ? 8'h00 : r.step + 8'h01;
        case (r.state)
            ST_RESET: begin
                if (step_done) begin
                    n.state = ST_WAKING1;
                end
            end
            ST_ASLEEP: begin
                n.step = 8'h00;
                if (pin_hit || timer_hit) begin
                    n.state = ST_WAKING1;
                end
            end
            ST_WAKING1: begin
                if (step_done) begin
                    n.state = ST_WAKING2;
                end
            end
            ST_WAKING2: begin
                if (step_done) begin
                    n.state = ST_AWAKE_WAIT;
                end
            end
            ST_AWAKE_WAIT: begin
                if (step_done) begin
                    n.state = ST_AWAKE;
                end
            end
            ST_AWAKE: begin
                n.step = 8'h00;
                if (r.sleep_go) begin
                    n.state = ST_SLEEPING1;
                end else if (r.reapply) begin
                    n.applied = r.awake_cfg;
                end
            end
            ST_SLEEPING1: begin
                if (step_done) begin
                    n.state = ST_SLEEPING2;
                end
            end
            ST_SLEEPING2: begin
                if (step_done) begin
                    n.state = ST_ASLEEP;
                end
            end
            default: n.state = ST_RESET;
        endcase

        // on every change the old enables become the previous-state report
        if (n.state != r.state) begin
            n.prev    = r.applied[5:0] & PREV_MASK;
            n.applied = (n.state == ST_AWAKE) ? r.awake_cfg
                      : pwr_for(n.state, r.asleep_cfg);
            n.step    = 8'h00;
        end
        // level is chosen once, as the wake sequence begins
        if (n.state == ST_WAKING1 && r.state != ST_WAKING1) begin
            n.level_out = r.ctrl[B_POR_LEVEL] ? POR_LEVEL : r.level;
        end
        // outside the asleep state the default clock always runs
        n.sclk_def = (n.state == ST_ASLEEP) ? n.ctrl[B_SLEEP_CLK]
                                            : 1'b1;
    end

    // ****************************************
    // state register
    // ****************************************
    // retained bytes clear only on the external reset, not on sleep
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            r            <= '0;
            r.ctrl       <= CTRL_RST;
            r.awake_cfg  <= AWAKE_RST;
            r.asleep_cfg <= ASLEEP_RST;
            r.level      <= POR_LEVEL;
            r.level_out  <= POR_LEVEL;
            r.prev       <= PREV_RST;
            r.state      <= ST_RESET;
            r.sclk_def   <= 1'b1;
        end else begin
            r <= n;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign s_axi_awready           = r.awready;
    assign s_axi_wready            = r.wready;
    assign s_axi_bvalid            = r.bvalid;
    assign s_axi_bresp             = r.bresp;
    assign s_axi_arready           = r.arready;
    assign s_axi_rvalid            = r.rvalid;
    assign s_axi_rresp             = r.rresp;
    assign s_axi_rdata             = r.rdata;
    assign io_supply_output_en     = r.applied[5];
    assign pll_linear_regulator_en = r.applied[4];
    assign analogue_converter_en   = r.applied[1];
    assign core_converter_en       = r.applied[0];
    assign analogue_converter_pfm  = r.applied[9];
    assign core_converter_pfm      = r.applied[8];
    assign tile_clock_off          = r.applied[14];
    assign sleep_clock_default     = r.sclk_def;
    assign supply_level            = r.level_out;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    sleep_start_a: assert property (r.state == ST_AWAKE && r.sleep_go
        |=> r.state == ST_SLEEPING1 ##1 (r.state == ST_SLEEPING1)[*7])
        else $error("sleep request did not start the sleep sequence");
    oneshot_clear_a: assert property (r.sleep_go || r.reapply
        |=> !r.sleep_go && !r.reapply && !r.ctrl[B_SLEEP_GO])
        else $error("one-shot control bit did not clear");
    pin_wake_a: assert property (r.state == ST_ASLEEP && r.ctrl[B_PIN_EN]
        && r.pin_s2 == r.ctrl[B_PIN_POL] |=> r.state == ST_WAKING1)
        else $error("pin at wake level did not wake the device");
    no_pin_wake_a: assert property (r.state == ST_ASLEEP && !timer_hit
        && r.pin_s2 != r.ctrl[B_PIN_POL] |=> r.state == ST_ASLEEP)
        else $error("device woke with pin at the wrong level");
    timer_wake_a: assert property (r.state == ST_ASLEEP && r.ctrl[B_TIMER_EN]
        && !r.ctrl[B_TIMER_64] && r.timer[31:0] >= r.wake_lo
        |=> r.state == ST_WAKING1)
        else $error("timer reaching wake time did not wake the device");
    sleep_clock_a: assert property (r.state != ST_ASLEEP
        |-> sleep_clock_default)
        else $error("sleep clock selection leaked outside asleep state");
    prev_report_a: assert property (r.state != $past(r.state)
        |-> r.prev == ($past(r.applied[5:0]) & PREV_MASK))
        else $error("previous-state enables not captured on change");
    reapply_a: assert property (r.state == ST_AWAKE && r.reapply && !r.sleep_go
        |=> r.applied == $past(r.awake_cfg))
        else $error("awake configuration was not re-applied");
    wake_level_a: assert property (r.state == ST_ASLEEP ##1 r.state == ST_WAKING1
        |-> supply_level == ($past(r.ctrl[B_POR_LEVEL]) ? POR_LEVEL
                                                        : $past(r.level)))
        else $error("wrong supply level applied on wake");
    awake_supply_a: assert property (r.state == ST_AWAKE_WAIT ##1 r.state == ST_AWAKE
        |-> r.applied == $past(r.awake_cfg, 2) || r.applied == $past(r.awake_cfg))
        else $error("awake configuration not applied on entry");

    sleep_entry_c: cover property (r.state == ST_SLEEPING2 ##1 r.state == ST_ASLEEP);
    pin_wake_c:    cover property (r.state == ST_ASLEEP && pin_hit ##1 r.state == ST_WAKING1);
    timer_wake_c:  cover property (r.state == ST_ASLEEP && timer_hit && r.ctrl[B_TIMER_64]);
    reapply_c:     cover property (r.state == ST_AWAKE && r.reapply);

endmodule

`default_nettype wire

// *** verification/sleep_wake_power_sequencer_bench.sv ***
// bench: register, sleep and wake checks of the power sequencer
`timescale 1ns/1ps
`default_nettype none
module sleep_wake_power_sequencer_bench;
    import swps_pkg::*;
    logic clk_sys = 0, arst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0, act = 0, pol = 1;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rv;
    logic [3:0]  s_axi_wstrb = 4'hF;
    logic [1:0]  s_axi_bresp, s_axi_rresp, rr, rb;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, wake_pin;
    logic io_supply_output_en, pll_linear_regulator_en, analogue_converter_en;
    logic core_converter_en, analogue_converter_pfm, core_converter_pfm, tile_clock_off;
    logic sleep_clock_default;
    logic [7:0]  supply_level;
    int fail_count = 0, check_count = 0, cyc = 0;
    logic [11:0] ta[4] = '{OFF_CTRL, OFF_WAKE_LO, OFF_STATUS, 12'h7FC};
    logic [31:0] tm[4] = '{32'hFF, 32'hFFFF_FFFF, 32'h0007_0000, 32'hFF};
    logic [31:0] te[4] = '{32'h08, 32'h0, 32'h0005_0000, 32'h0};
    swps_top dut_u (
        .clk_sys(clk_sys), .arst_n(arst_n),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .wake_pin(wake_pin),
        .io_supply_output_en(io_supply_output_en),
        .pll_linear_regulator_en(pll_linear_regulator_en),
        .analogue_converter_en(analogue_converter_en),
        .core_converter_en(core_converter_en),
        .analogue_converter_pfm(analogue_converter_pfm),
        .core_converter_pfm(core_converter_pfm),
        .tile_clock_off(tile_clock_off),
        .sleep_clock_default(sleep_clock_default),
        .supply_level(supply_level)
    );
    swps_wake_src wk_u (.clk_sys(clk_sys), .active(act), .high_wakes(pol), .wake_pin(wake_pin));
    // 200 MHz clock; ceiling cuts a hung handshake short
    initial forever #2.5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 30000) begin
            fail_count++;
            results();
        end
    end
    // ****
    // bus and compare tasks
    // ****
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("ERROR %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        s_axi_awaddr <= a; s_axi_wdata <= d;
        s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
        do begin
            @(posedge clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (!s_axi_bvalid);
        // bready stays high between writes, so no second drive in one step
        rb = s_axi_bresp;
    endtask
    task automatic rd(input logic [11:0] a);
        s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
        do begin
            @(posedge clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (!s_axi_rvalid);
        rv = s_axi_rdata;
        rr = s_axi_rresp;
    endtask
    // poll the state field, bounded, then compare
    task automatic st(input logic [2:0] s);
        for (int i = 0; i < 300; i++) begin
            rd(OFF_STATUS);
            if (rv[18:16] === s) break;
        end
        chk(32'(rv[18:16]), 32'(s));
    endtask
    // sleep and stay asleep while the wake cause is held off
    task automatic hold(input logic [31:0] c);
        wr(OFF_CTRL, c);
        st(ST_ASLEEP);
        chk(32'(sleep_clock_default), 32'(c[0]));
        repeat (50) @(posedge clk_sys);
        rd(OFF_STATUS);
        chk(32'(rv[18:16]), 32'(ST_ASLEEP));
    endtask
    task automatic results();
        $display("checks %0d errors %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // main sequence: table of reset reads, then sleep and wake paths
    initial begin
        repeat (10) @(posedge clk_sys);
        arst_n <= 1;
        st(ST_AWAKE);
        for (int i = 0; i < 4; i++) begin
            rd(ta[i]);
            chk(rv & tm[i], te[i]);
        end
        chk(32'({io_supply_output_en, pll_linear_regulator_en, analogue_converter_en,
            core_converter_en}), 32'({AWAKE_RST[5:4], AWAKE_RST[1:0]}));
        chk(32'({tile_clock_off, supply_level}), 32'({AWAKE_RST[14], POR_LEVEL}));
        rd(12'h030);
        chk(32'(rr), 32'(RESP_SLVERR));
        wr(12'h030, 32'h0);
        chk(32'(rb), 32'(RESP_SLVERR));
        wr(12'h5FC, 32'hA5);
        wr(12'h7FC, 32'h01);
        chk(32'(rb), 32'(RESP_OKAY));
        wr(OFF_LEVEL, 32'h3C);
        wr(OFF_CTRL, 32'h0E);
        rd(OFF_CTRL);
        chk(rv & 32'hFF, 32'h0C);
        st(ST_ASLEEP);
        chk(32'(sleep_clock_default), 32'h0);
        chk(32'({io_supply_output_en, pll_linear_regulator_en, analogue_converter_en,
            core_converter_en, tile_clock_off}),
            32'({ASLEEP_RST[5:4], ASLEEP_RST[1:0], ASLEEP_RST[14]}));
        rd(OFF_STATUS);
        chk(rv & 32'h3300_0000, 32'(PWR_CORE_ANA[5:0]) << B_PREV_LO);
        act <= 1;
        st(ST_AWAKE);
        chk(32'(sleep_clock_default), 32'h1);
        chk(32'(supply_level), 32'h3C);
        rd(12'h5FC);
        chk(rv, 32'hA5);
        rd(12'h7FC);
        chk(rv, 32'h01);
        act <= 0;
        wr(OFF_AWAKE, 32'h333);
        wr(OFF_CTRL, 32'h48);
        rd(OFF_STATUS);
        chk(rv & 32'h333, 32'h333);
        chk(32'({analogue_converter_pfm, core_converter_pfm}), 32'h3);
        wr(OFF_WAKE_LO, 32'hFFFF_FFFF);
        hold(32'h9B);
        wr(OFF_WAKE_LO, 32'h0);
        st(ST_AWAKE);
        chk(32'(supply_level), 32'(POR_LEVEL));
        wr(OFF_WAKE_HI, 32'h1);
        hold(32'h3A);
        wr(OFF_WAKE_HI, 32'h0);
        st(ST_AWAKE);
        // low level wakes once the polarity bit is cleared
        pol <= 0;
        wr(OFF_CTRL, 32'h06);
        st(ST_ASLEEP);
        act <= 1;
        st(ST_AWAKE);
        // reset in mid-run: outputs at reset values, validity byte cleared
        act <= 0;
        arst_n <= 0;
        repeat (3) @(posedge clk_sys);
        chk(32'({s_axi_awready, s_axi_arready, s_axi_bvalid, s_axi_rvalid, core_converter_en,
            sleep_clock_default, supply_level}), 32'({1'b1, POR_LEVEL}));
        arst_n <= 1;
        st(ST_AWAKE);
        rd(12'h7FC);
        chk(rv, 32'h0);
        results();
    end
endmodule
`default_nettype wire

// *** verification/swps_wake_src.sv ***
// wake pin source standing in for the external wake switch
`timescale 1ns/1ps
`default_nettype none
module swps_wake_src (
    input  wire logic clk_sys,
    input  wire logic active,
    input  wire logic high_wakes,
    output logic      wake_pin
);
    // idle level is the inverse of the waking level, never left floating
    always_ff @(posedge clk_sys) begin
        wake_pin <= active ? high_wakes : ~high_wakes;
    end
endmodule
`default_nettype wire
